// [rtl/asr_pkg.sv]
// package: constants, types and timing for the static ram host controller
package asr_pkg;
   localparam int unsigned ADDR_W      = 13;      // 8192 locations
   localparam int unsigned DATA_W      = 8;       // one byte per location
   localparam int unsigned CLK_NS      = 10;      // 100 MHz system clock
   // timing in ns, slower grade so either part works
   localparam int unsigned T_ACC_NS    = 200;     // address access, longest
   localparam int unsigned T_DH_NS     = 20;      // output hold after address change
   localparam int unsigned T_ODO_NS    = 80;      // output enable to high-z, longest
   localparam int unsigned T_WP_NS     = 150;     // write pulse width, least
   localparam int unsigned T_DS_NS     = 80;      // data setup before end of write
   localparam int unsigned T_WC_NS     = 200;     // write cycle time, least
   // cycle counts, times rounded up; access time gets one extra cycle
   localparam int unsigned ACC_CYC  = (T_ACC_NS + CLK_NS - 1) / CLK_NS + 1;
   localparam int unsigned ODO_CYC  = (T_ODO_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned WP_CYC   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned WREC_CYC = (T_WC_NS - T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned CNT_W    = 5;
   localparam logic [CNT_W-1:0] ACC_CNT  = CNT_W'(ACC_CYC - 1);
   localparam logic [CNT_W-1:0] ODO_CNT  = CNT_W'(ODO_CYC - 1);
   localparam logic [CNT_W-1:0] WP_CNT   = CNT_W'(WP_CYC - 1);
   localparam logic [CNT_W-1:0] WREC_CNT = CNT_W'(WREC_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
   // write end modes: which pin ends the write pulse
   typedef enum logic [1:0] {
      WEND_RW   = 2'h0,
      WEND_SELL = 2'h1,
      WEND_SELH = 2'h2
   } asr_wend_t;
   // pins toward the memory
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic              select_active_low;
      logic              select_active_high;
      logic              out_en_n;
      logic              read_write;
   } asr_pins_t;
   // user request
   typedef struct packed {
      logic              write;
      asr_wend_t         wend;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } asr_req_t;
   // controller states, gray along the main path
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_RACC  = 3'h1,
      ST_RFLT  = 3'h3,
      ST_WPUL  = 3'h2,
      ST_WREC  = 3'h6
   } asr_state_t;
endpackage

// [rtl/asr_host.sv]
// host controller driving an asynchronous 8k x 8 static ram over its pins
`timescale 1ns/100ps
module asr_host
   import asr_pkg::*;
(
   input  wire logic              i_clk_sys,   // 100 MHz clock
   input  wire logic              i_rst,       // synchronous, active high
   input  wire logic              i_req_valid, // request offered
   input  wire asr_req_t          i_req,       // request contents
   input  wire logic              i_standby,   // keep memory deselected
   output logic                   o_req_ready, // request taken this cycle
   output logic                   o_rd_valid,  // read byte valid pulse
   output logic [DATA_W-1:0]      o_rd_data,   // last read byte
   output asr_pins_t              o_pins,      // control and address pins
   input  wire logic [DATA_W-1:0] i_data_bus_bits,  // data pins in
   output logic [DATA_W-1:0]      o_data_bus_bits,  // data pins out
   output logic                   o_data_bus_oe     // high while host drives
);
   asr_state_t        state_q;   // controller state
   logic [CNT_W-1:0]  cnt_q;     // phase timer
   asr_req_t          req_q;     // request under way
   asr_pins_t         pins_q;    // registered pins
   logic              oe_q;      // data bus drive enable
   logic [DATA_W-1:0] rdat_q;    // captured read byte
   logic              rvld_q;    // read valid pulse

   // ready only when idle and not held in standby
   assign o_req_ready = (state_q == ST_IDLE) && !i_standby;
   assign o_pins          = pins_q;
   assign o_data_bus_bits = req_q.wdata;
   assign o_data_bus_oe   = oe_q;
   assign o_rd_data       = rdat_q;
   assign o_rd_valid      = rvld_q;

   // state and phase timer
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_q <= ST_IDLE;
         cnt_q   <= CNT_ZERO;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (i_req_valid && o_req_ready) begin
                  state_q <= i_req.write ? ST_WPUL : ST_RACC;
                  cnt_q   <= i_req.write ? WP_CNT : ACC_CNT;
               end
            end
            ST_RACC: begin
               // hold address the full access time before sampling
               if (cnt_q == CNT_ZERO) begin
                  state_q <= ST_RFLT;
                  cnt_q   <= ODO_CNT;
               end else begin
                  cnt_q <= cnt_q - 5'h01;
               end
            end
            ST_RFLT: begin
               // memory bus must float before a write may drive it
               if (cnt_q == CNT_ZERO) begin
                  state_q <= ST_IDLE;
               end else begin
                  cnt_q <= cnt_q - 5'h01;
               end
            end
            ST_WPUL: begin
               // pulse width covers data setup too (150 > 80)
               if (cnt_q == CNT_ZERO) begin
                  state_q <= ST_WREC;
                  cnt_q   <= WREC_CNT;
               end else begin
                  cnt_q <= cnt_q - 5'h01;
               end
            end
            ST_WREC: begin
               if (cnt_q == CNT_ZERO) begin
                  state_q <= ST_IDLE;
               end else begin
                  cnt_q <= cnt_q - 5'h01;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               cnt_q   <= CNT_ZERO;
            end
         endcase
      end
   end

   // request latch; address stays stable for the whole cycle
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         req_q <= '0;
      end else if (state_q == ST_IDLE && i_req_valid && o_req_ready) begin
         req_q <= i_req;
      end
   end

   // pin drive: deselected means standby with data kept
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         pins_q.addr               <= '0;
         pins_q.select_active_low  <= 1'b1;
         pins_q.select_active_high <= 1'b0;
         pins_q.out_en_n           <= 1'b1;
         pins_q.read_write         <= 1'b1;
         oe_q                      <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (i_req_valid && o_req_ready) begin
                  // address changes only here, so each one starts a precharge
                  pins_q.addr               <= i_req.addr;
                  pins_q.select_active_low  <= 1'b0;
                  pins_q.select_active_high <= 1'b1;
                  pins_q.out_en_n           <= i_req.write;
                  // rw falls with select, never after it
                  pins_q.read_write         <= !i_req.write;
                  oe_q                      <= i_req.write;
               end else begin
                  // idle deselected; standby needs no extra delay
                  pins_q.select_active_low  <= 1'b1;
                  pins_q.select_active_high <= 1'b0;
                  pins_q.out_en_n           <= 1'b1;
                  pins_q.read_write         <= 1'b1;
                  oe_q                      <= 1'b0;
               end
            end
            ST_RACC: begin
               if (cnt_q == CNT_ZERO) begin
                  pins_q.out_en_n          <= 1'b1;
                  pins_q.select_active_low <= 1'b1;
                  pins_q.select_active_high <= 1'b0;
               end
            end
            ST_WPUL: begin
               if (cnt_q == CNT_ZERO) begin
                  // end the write on the chosen pin; rw stays low if select ends it
                  case (req_q.wend)
                     WEND_SELL: pins_q.select_active_low  <= 1'b1;
                     WEND_SELH: pins_q.select_active_high <= 1'b0;
                     default:   pins_q.read_write         <= 1'b1;
                  endcase
               end
            end
            ST_WREC: begin
               // deselect on entry; data held 50 ns past end, rw of a select-ended write rises then too
               pins_q.select_active_low  <= 1'b1;
               pins_q.select_active_high <= 1'b0;
               if (cnt_q == CNT_ZERO) begin
                  pins_q.read_write <= 1'b1;
                  oe_q              <= 1'b0;
               end
            end
            default: begin
               pins_q.out_en_n <= 1'b1;
            end
         endcase
      end
   end

   // read capture at the end of access time; the old byte still holds
   // for a moment after address change, but we never sample that early
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         rdat_q <= '0;
         rvld_q <= 1'b0;
      end else begin
         rvld_q <= (state_q == ST_RACC) && (cnt_q == CNT_ZERO);
         if ((state_q == ST_RACC) && (cnt_q == CNT_ZERO)) begin
            rdat_q <= i_data_bus_bits;
         end
      end
   end

   // sequence for the start of a write
   sequence s_wr_start;
      $fell(pins_q.read_write);
   endsequence

   a_sel_legal: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (!pins_q.select_active_low && pins_q.select_active_high) |-> !o_req_ready)
      else $error("memory selected while host idle");
   a_read_pins: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !pins_q.out_en_n |-> (pins_q.read_write && !oe_q))
      else $error("output enable low outside a read");
   a_wr_sel_with: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      s_wr_start |-> !pins_q.select_active_low && pins_q.select_active_high)
      else $error("select not present as rw falls");
   // an rw-ended write raises rw while selected; output enable high keeps the ram off the bus
   a_wr_rw_last: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $rose(pins_q.read_write) |-> pins_q.out_en_n
         && ((req_q.wend == WEND_RW) || pins_q.select_active_low
             || !pins_q.select_active_high))
      else $error("rw rose while still selected after a select-ended write");
   a_wr_oe_high: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !pins_q.read_write |-> pins_q.out_en_n)
      else $error("output enable low during write");
   a_wr_pulse: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      s_wr_start |-> (!pins_q.read_write && oe_q) [*8])
      else $error("write pulse too short");
   a_rd_access: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $fell(pins_q.out_en_n) |-> ##21 o_rd_valid)
      else $error("read sampled at wrong time");
   a_rd_float: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $rose(pins_q.out_en_n) && !oe_q |-> !o_req_ready [*8])
      else $error("new access before bus floated");
   a_addr_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !o_req_ready && !$past(o_req_ready) && state_q != ST_IDLE
      |-> $stable(pins_q.addr))
      else $error("address moved during an access");
endmodule // asr_host

// [verif/asr_sram_model.sv]
// behavioural model of the 8k x 8 static ram as seen from the host pins
`timescale 1ns/100ps
module asr_sram_model
   import asr_pkg::*;
#(
   parameter int ACC_NS = 190  // access delay, inside the slow grade
)(
   input  wire asr_pins_t         i_pins,  // pins from the host
   input  wire logic [DATA_W-1:0] i_bus,   // resolved data wire
   output logic [DATA_W-1:0]      o_data,  // byte the ram drives
   output logic                   o_oe     // high while the ram drives
);
   logic [DATA_W-1:0] mem [0:(2**ADDR_W)-1]; // storage array
   logic              sel;                   // chip selected
   logic              wr_act;                // write pulse active
   // both enables must agree, otherwise standby
   assign sel    = ~i_pins.select_active_low & i_pins.select_active_high;
   assign wr_act = sel & ~i_pins.read_write;
   // drives only in a read; output enable high floats at once, the fastest case
   assign o_oe   = sel & i_pins.read_write & ~i_pins.out_en_n;
   // store at whichever pin ends the pulse first
   always @(negedge wr_act) begin
      mem[i_pins.addr] = i_bus;
   end
   // old byte holds briefly, then garbage until the access time runs out
   // scheduled, not waited, so no address change is missed while a delay runs
   always @(i_pins.addr or sel) begin
      o_data <= #20 ~mem[i_pins.addr];
      o_data <= #(ACC_NS) mem[i_pins.addr];
   end
endmodule // asr_sram_model

// [verif/tb_top.sv]
// self-checking bench for the static ram host controller
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin errors++; \
   $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module tb_top;
   import asr_pkg::*;
   logic              clk;              // system clock
   logic              rst;              // sync reset
   logic              req_valid;        // request offered
   asr_req_t          req;              // request contents
   logic              standby;          // hold ram deselected
   logic              req_ready;        // request taken
   logic              rd_valid;         // read byte pulse
   logic [DATA_W-1:0] rd_data;          // read byte
   asr_pins_t         pins;             // control pins
   logic [DATA_W-1:0] host_d;           // host data out
   logic              host_oe;          // host drives wire
   logic [DATA_W-1:0] ram_d;            // ram data out
   logic              ram_oe;           // ram drives wire
   logic [DATA_W-1:0] bus;              // resolved wire
   logic [DATA_W-1:0] last_q = 8'h00;   // last wire level
   int                errors = 0;       // mismatches
   int                total_checks = 0; // comparisons
   int                cyc = 0;          // hang limit counter
   asr_host asr_host_i (.i_clk_sys(clk), .i_rst(rst), .i_req_valid(req_valid), .i_req(req),
      .i_standby(standby), .o_req_ready(req_ready), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
      .o_pins(pins), .i_data_bus_bits(bus), .o_data_bus_bits(host_d), .o_data_bus_oe(host_oe));
   asr_sram_model asr_sram_model_i (.i_pins(pins), .i_bus(bus), .o_data(ram_d), .o_oe(ram_oe));
   // no pull on the wire, so a floating bus shows a changing pattern
   assign bus = host_oe ? host_d : (ram_oe ? ram_d : ~last_q);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // contention watch and hang limit
   always @(posedge clk) begin
      last_q <= bus;
      cyc    <= cyc + 1;
      if (rst === 1'b0) `CHK("contention", 1'b0, host_oe & ram_oe)
      if (cyc == 2000) begin
         errors++;
         final_report();
      end
   end
   task automatic final_report;
      if (errors == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // offer a request and hold it until taken; returns at the falling edge right after the take
   task automatic issue(input logic w, input asr_wend_t we, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      @(negedge clk);
      req_valid = 1'b1;
      req       = '{w, we, a, d};
      while (req_ready !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      `CHK("ready", 1'b1, req_ready)
      @(negedge clk);
      req_valid = 1'b0;
   endtask
   // one write, checking pin phases and the ending pin at cycle 15
   task automatic do_write(input asr_wend_t we, input logic [ADDR_W-1:0] a,
                           input logic [DATA_W-1:0] d);
      issue(1'b1, we, a, d);
      `CHK("wr_oe_n", 1'b1, pins.out_en_n)
      `CHK("wr_ctl", 3'b010, {pins.select_active_low, pins.select_active_high, pins.read_write})
      `CHK("wr_drive", 1'b1, host_oe)
      `CHK("wr_data", d, host_d)
      repeat (15) @(negedge clk);
      `CHK("wr_end", (we == WEND_RW) ? 3'b011 : (we == WEND_SELL) ? 3'b110 : 3'b000, {pins.select_active_low, pins.select_active_high, pins.read_write})
   endtask
   // one read, checking pins, latency, float and data
   task automatic do_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ex);
      int k;
      issue(1'b0, WEND_RW, a, 8'h00);
      `CHK("rd_ctl", 4'h5, {pins.select_active_low, pins.select_active_high, pins.out_en_n, pins.read_write})
      `CHK("rd_addr", a, pins.addr)
      k = 0;
      while (rd_valid !== 1'b1 && k < 40) begin
         @(negedge clk);
         k++;
      end
      `CHK("rd_lat", 21, k)
      `CHK("rd_float", 1'b1, pins.out_en_n)
      `CHK("rd_data", ex, rd_data)
   endtask
   // pins straight after reset
   task automatic check_reset;
      `CHK("rst_pins", 17'h0000B, pins)
      `CHK("rst_oe", 1'b0, host_oe)
      `CHK("rst_ready", 1'b1, req_ready)
   endtask
   // all three write endings, boundary addresses included
   task automatic write_modes;
      do_write(WEND_RW, 13'h0000, 8'hA5);
      do_write(WEND_SELL, 13'h1FFF, 8'h5A);
      do_write(WEND_SELH, 13'h0AAA, 8'h3C);
   endtask
   // standby deselects and blocks requests
   task automatic standby_hold;
      @(negedge clk);
      standby = 1'b1;
      // wait past the write recovery so only standby can hold ready low
      repeat (8) @(negedge clk);
      `CHK("sb_ready", 1'b0, req_ready)
      `CHK("sb_sel", 2'b10, {pins.select_active_low, pins.select_active_high})
      standby = 1'b0;
      @(negedge clk);
      `CHK("sb_release", 1'b1, req_ready)
   endtask
   // contents kept through standby, then overwritten back to back
   task automatic readback;
      do_read(13'h0000, 8'hA5);
      do_read(13'h1FFF, 8'h5A);
      do_read(13'h0AAA, 8'h3C);
      do_write(WEND_SELL, 13'h0000, 8'hC3);
      do_read(13'h0000, 8'hC3);
   endtask
   initial begin
      rst       = 1'b1;
      req_valid = 1'b0;
      req       = '0;
      standby   = 1'b0;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      check_reset();
      write_modes();
      standby_hold();
      readback();
      final_report();
   end
endmodule // tb_top
